// ==== jtt_pkg.sv ====
`default_nettype none
package jtt_pkg;
  localparam int ENTRIES  = 32;
  localparam int IDX_W    = 5;
  localparam int VA_W     = 64;
  localparam int PA_W     = 32;
  localparam int DATA_W   = 64;
  localparam int ADDRESS_SPACE_ID_W   = 8;
  localparam int MASK_W   = 8;
  localparam int OFF_MIN  = 10;
  localparam int OFF_W    = MASK_W + OFF_MIN;
  localparam int SEL_W    = OFF_W + 1;
  localparam int VPN_LSB  = 11;
  localparam int VPN_W    = 29;
  localparam int PFN_W    = 22;
  localparam int LO_W     = 28;
  localparam int WIRED_W  = 6;
  localparam int RADDR_W  = 6;
  localparam int EV_W     = 3;
  localparam int SEG32_W  = 3;
  localparam int XUSER_LSB = 40;
  localparam int XUSER_W   = 24;
  localparam int CTX_LSB  = 25;
  localparam int XCTX_LSB = 33;
  localparam int BAD_LSB  = 4;
  localparam int BAD32_W  = 21;
  localparam int PFAIL_BIT = 31;
  localparam int LO_G     = 0;
  localparam int LO_V     = 1;
  localparam int LO_PFN_LSB = 6;
  localparam int SIZE_LSB = 11;
  localparam int KDIR_W   = 29;
  // coprocessor register numbers
  localparam logic [RADDR_W-1:0] REG_INDEX = 6'h00;
  localparam logic [RADDR_W-1:0] REG_RANDOM = 6'h01;
  localparam logic [RADDR_W-1:0] REG_LO0 = 6'h02;
  localparam logic [RADDR_W-1:0] REG_LO1 = 6'h03;
  localparam logic [RADDR_W-1:0] REG_CTX = 6'h04;
  localparam logic [RADDR_W-1:0] REG_SIZE = 6'h05;
  localparam logic [RADDR_W-1:0] REG_WIRED = 6'h06;
  localparam logic [RADDR_W-1:0] REG_BADVA = 6'h08;
  localparam logic [RADDR_W-1:0] REG_HI = 6'h0a;
  localparam logic [RADDR_W-1:0] REG_XCTX = 6'h14;
  localparam logic [RADDR_W-1:0] REG_IRQ_STAT = 6'h20;
  localparam logic [RADDR_W-1:0] REG_IRQ_CLR = 6'h21;
  localparam logic [RADDR_W-1:0] REG_IRQ_EN = 6'h22;
  localparam logic [IDX_W-1:0] RANDOM_RST = 5'h1f;
  localparam logic [WIRED_W-1:0] WIRED_RST = 6'h00;
  localparam logic [OFF_MIN-1:0] OFF_ONES = 10'h3ff;
  localparam logic [SEG32_W-1:0] SSEG_TOP = 3'h6;
  localparam logic [1:0] KDIR_TOP = 2'h2;
  localparam logic [XUSER_W-1:0] XSSEG_TOP = 24'h400000;
  localparam int EV_MISS = 0;
  localparam int EV_AERR = 1;
  localparam int EV_PFAIL = 2;
  typedef enum logic [2:0] {
    JTT_PRIV_USER = 3'h1, JTT_PRIV_SUPER = 3'h2, JTT_PRIV_KERN = 3'h4
  } jtt_priv_t;
  typedef enum logic [3:0] {
    JTT_OP_READ = 4'h1, JTT_OP_WIDX = 4'h2, JTT_OP_WRND = 4'h4, JTT_OP_PROBE = 4'h8
  } jtt_op_t;
  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [RADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } jtt_reg_req_t;
  typedef struct packed {
    logic      valid;
    jtt_op_t   op;
  } jtt_cmd_t;
  typedef struct packed {
    logic            valid;
    logic            mode64;
    jtt_priv_t       priv;
    logic [VA_W-1:0] vaddr;
  } jtt_lk_req_t;
  typedef struct packed {
    logic            hit;
    logic            miss;
    logic            aerr;
    logic [PA_W-1:0] paddr;
  } jtt_lk_rsp_t;
endpackage : jtt_pkg
`default_nettype wire

// ==== jtt_top.sv ====
// Behaviour
// - 32 entries, all searched at once on every lookup.
// - each entry maps an even and an odd page, 64 pages total.
// - per-entry page size from 1 KB up to 256 KB.
// - entry writes copy the page-size register into the entry size field.
// - hit needs equal page number and either global set or equal space id.
// - no matching entry raises a translation-miss exception.
// - translated addresses are 32-bit physical, 4 Gbyte space.
// - register 0 is the writable entry pointer for reads and writes.
// - register 1 is a read-only pseudo-random replacement pointer.
// - registers 2 and 3 hold even and odd page low halves.
// - register 10 holds entry high half with the space id.
// - register 6 holds the wired entry count.
// - registers 4 and 20 point to kernel page-table entries, 32 and 64 bit.
// - register 8 captures the last faulting virtual address.
// - 32-bit mode splits space into 2 Gbyte user and 2 Gbyte kernel.
// - 64-bit mode gives a 1 Tbyte user space.
// - mapping depends on user, supervisor or kernel privilege.
// - registers 7, 21 to 25 and 31 are reserved, no function.
`timescale 1ns/1ps
`default_nettype none
module jtt_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire jtt_pkg::jtt_reg_req_t     reg_i,
  output var  logic [jtt_pkg::DATA_W-1:0] rdata_o,
  input  wire jtt_pkg::jtt_lk_req_t      lk_i,
  output var  jtt_pkg::jtt_lk_rsp_t      lk_o,
  input  wire jtt_pkg::jtt_cmd_t         cmd_i,
  output var  logic                      irq_o
);
  // entry store
  logic [jtt_pkg::VPN_W-1:0]  e_vpn  [jtt_pkg::ENTRIES];
  logic [jtt_pkg::MASK_W-1:0] e_mask [jtt_pkg::ENTRIES];
  logic [jtt_pkg::ADDRESS_SPACE_ID_W-1:0] e_address_space_id [jtt_pkg::ENTRIES];
  logic                       e_g    [jtt_pkg::ENTRIES];
  logic [jtt_pkg::LO_W-1:0]   e_lo0  [jtt_pkg::ENTRIES];
  logic [jtt_pkg::LO_W-1:0]   e_lo1  [jtt_pkg::ENTRIES];

  logic [jtt_pkg::IDX_W-1:0]   index_r;
  logic                        pfail_r;
  logic [jtt_pkg::IDX_W-1:0]   random_r;
  logic [jtt_pkg::LO_W-1:0]    lo0_r;
  logic [jtt_pkg::LO_W-1:0]    lo1_r;
  logic [jtt_pkg::MASK_W-1:0]  size_r;
  logic [jtt_pkg::WIRED_W-1:0] wired_r;
  logic [jtt_pkg::VA_W-1:0]    badva_r;
  logic [jtt_pkg::VPN_W-1:0]   hi_vpn_r;
  logic [jtt_pkg::ADDRESS_SPACE_ID_W-1:0]  hi_address_space_id_r;
  logic [jtt_pkg::DATA_W-jtt_pkg::CTX_LSB-1:0]  ctx_base_r;
  logic [jtt_pkg::DATA_W-jtt_pkg::XCTX_LSB-1:0] xctx_base_r;
  logic [jtt_pkg::EV_W-1:0]    stat_r;
  logic [jtt_pkg::EV_W-1:0]    en_r;
  logic [jtt_pkg::EV_W-1:0]    stat_nxt;
  logic [jtt_pkg::EV_W-1:0]    ev;
  logic [jtt_pkg::DATA_W-1:0]  rdata_nxt;

  function automatic logic [jtt_pkg::ENTRIES-1:0] match_vec(
      input logic [jtt_pkg::VPN_W-1:0]  virtual_page_number,
      input logic [jtt_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id);
    logic [jtt_pkg::ENTRIES-1:0] m;
    m = '0;
    for (int i = 0; i < jtt_pkg::ENTRIES; i++) begin
      // low page-number bits inside a large page are ignored
      m[i] = (((virtual_page_number ^ e_vpn[i]) & ~{{(jtt_pkg::VPN_W-jtt_pkg::MASK_W){1'b0}}, e_mask[i]})
              == '0) && (e_g[i] || (e_address_space_id[i] == address_space_id));
    end
    return m;
  endfunction : match_vec

  function automatic logic [jtt_pkg::IDX_W-1:0] first_idx(
      input logic [jtt_pkg::ENTRIES-1:0] v);
    logic [jtt_pkg::IDX_W-1:0] k;
    k = '0;
    for (int i = jtt_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        k = jtt_pkg::IDX_W'(i);
      end
    end
    return k;
  endfunction : first_idx

  // decoded strobes
  logic wr_en;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_pr;
  logic [jtt_pkg::IDX_W-1:0] wr_idx;
  assign wr_en  = reg_i.wr;
  assign cmd_rd = cmd_i.valid && (cmd_i.op == jtt_pkg::JTT_OP_READ);
  assign cmd_wr = cmd_i.valid && ((cmd_i.op == jtt_pkg::JTT_OP_WIDX) ||
                                  (cmd_i.op == jtt_pkg::JTT_OP_WRND));
  assign cmd_pr = cmd_i.valid && (cmd_i.op == jtt_pkg::JTT_OP_PROBE);
  assign wr_idx = (cmd_i.op == jtt_pkg::JTT_OP_WRND) ? random_r : index_r;

  // lookup path
  logic [jtt_pkg::VA_W-1:0]    va;
  logic [jtt_pkg::ENTRIES-1:0] lk_match;
  logic [jtt_pkg::IDX_W-1:0]   lk_idx;
  logic [jtt_pkg::OFF_W-1:0]   om;
  logic [jtt_pkg::SEL_W-1:0]   sel;
  logic                        odd;
  logic [jtt_pkg::LO_W-1:0]    lo_sel;
  logic [jtt_pkg::PA_W-1:0]    off_mask;
  logic [jtt_pkg::PA_W-1:0]    map_pa;
  logic                        seg_ok;
  logic                        unmapped;
  logic                        ext_ok;
  logic                        lk_hit;
  logic                        lk_miss;
  logic                        lk_aerr;
  logic [jtt_pkg::PA_W-1:0]    lk_pa;

  assign va       = lk_i.vaddr;
  // always_comb, not assign: the function reads the entry arrays
  always_comb lk_match = match_vec(va[jtt_pkg::VPN_LSB +: jtt_pkg::VPN_W], hi_address_space_id_r);
  assign lk_idx   = first_idx(lk_match);
  assign om       = {e_mask[lk_idx], jtt_pkg::OFF_ONES};
  // first bit above the page offset chooses even or odd page
  assign sel      = {om, 1'b1} ^ {1'b0, om};
  assign odd      = |(va[jtt_pkg::SEL_W-1:0] & sel);
  assign lo_sel   = odd ? e_lo1[lk_idx] : e_lo0[lk_idx];
  assign off_mask = {{(jtt_pkg::PA_W-jtt_pkg::OFF_W){1'b0}}, om};
  assign map_pa   = ({lo_sel[jtt_pkg::LO_PFN_LSB +: jtt_pkg::PFN_W], {jtt_pkg::OFF_MIN{1'b0}}}
                     & ~off_mask) | (va[jtt_pkg::PA_W-1:0] & off_mask);

  always_comb begin
    seg_ok   = 1'b0;
    unmapped = 1'b0;
    ext_ok   = 1'b1;
    if (!lk_i.mode64) begin
      // 32-bit addresses must arrive sign-extended
      ext_ok = (va[jtt_pkg::VA_W-1:jtt_pkg::PA_W] == {(jtt_pkg::VA_W-jtt_pkg::PA_W){va[jtt_pkg::PA_W-1]}});
      case (lk_i.priv)
        jtt_pkg::JTT_PRIV_USER: seg_ok = !va[jtt_pkg::PA_W-1];
        jtt_pkg::JTT_PRIV_SUPER: begin
          seg_ok = !va[jtt_pkg::PA_W-1] ||
                   (va[jtt_pkg::PA_W-1 -: jtt_pkg::SEG32_W] == jtt_pkg::SSEG_TOP);
        end
        jtt_pkg::JTT_PRIV_KERN: begin
          seg_ok   = 1'b1;
          unmapped = (va[jtt_pkg::PA_W-1 -: 2] == jtt_pkg::KDIR_TOP);
        end
        default: seg_ok = 1'b0;
      endcase
    end else begin
      case (lk_i.priv)
        jtt_pkg::JTT_PRIV_USER: begin
          seg_ok = (va[jtt_pkg::VA_W-1:jtt_pkg::XUSER_LSB] == '0);
        end
        jtt_pkg::JTT_PRIV_SUPER: begin
          seg_ok = (va[jtt_pkg::VA_W-1:jtt_pkg::XUSER_LSB] == '0) ||
                   (va[jtt_pkg::VA_W-1:jtt_pkg::XUSER_LSB] == jtt_pkg::XSSEG_TOP);
        end
        jtt_pkg::JTT_PRIV_KERN: begin
          seg_ok   = 1'b1;
          unmapped = (va[jtt_pkg::VA_W-1 -: 2] == jtt_pkg::KDIR_TOP);
        end
        default: seg_ok = 1'b0;
      endcase
    end
    lk_aerr = lk_i.valid && !(seg_ok && ext_ok);
    // an invalid page counts as a miss so the handler refills it
    lk_miss = lk_i.valid && !lk_aerr && !unmapped &&
              !((|lk_match) && lo_sel[jtt_pkg::LO_V]);
    lk_hit  = lk_i.valid && !lk_aerr && !lk_miss;
    lk_pa   = unmapped ? ((va[jtt_pkg::VA_W-1 -: 2] == jtt_pkg::KDIR_TOP) && lk_i.mode64 ?
                          va[jtt_pkg::PA_W-1:0] :
                          {{(jtt_pkg::PA_W-jtt_pkg::KDIR_W){1'b0}}, va[jtt_pkg::KDIR_W-1:0]})
                       : map_pa;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_o <= '0;
    end else begin
      lk_o.hit   <= lk_hit;
      lk_o.miss  <= lk_miss;
      lk_o.aerr  <= lk_aerr;
      lk_o.paddr <= lk_hit ? lk_pa : '0;
    end
  end

  // entry writes, with the size register copied in
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < jtt_pkg::ENTRIES; i++) begin
        e_vpn[i]  <= '0;
        e_mask[i] <= '0;
        e_address_space_id[i] <= '0;
        e_g[i]    <= 1'b0;
        e_lo0[i]  <= '0;
        e_lo1[i]  <= '0;
      end
    end else if (cmd_wr) begin
      e_vpn[wr_idx]  <= hi_vpn_r;
      e_address_space_id[wr_idx] <= hi_address_space_id_r;
      e_mask[wr_idx] <= size_r;
      e_g[wr_idx]    <= lo0_r[jtt_pkg::LO_G] & lo1_r[jtt_pkg::LO_G];
      e_lo0[wr_idx]  <= lo0_r;
      e_lo1[wr_idx]  <= lo1_r;
    end
  end

  // probe searches with the high-half register contents
  logic [jtt_pkg::ENTRIES-1:0] pr_match;
  always_comb pr_match = match_vec(hi_vpn_r, hi_address_space_id_r);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_r <= '0;
      pfail_r <= 1'b0;
    end else if (cmd_pr) begin
      index_r <= (|pr_match) ? first_idx(pr_match) : index_r;
      pfail_r <= !(|pr_match);
    end else if (wr_en && (reg_i.addr == jtt_pkg::REG_INDEX)) begin
      index_r <= reg_i.wdata[jtt_pkg::IDX_W-1:0];
    end
  end
  // counts down to the wired floor then wraps; software cannot write it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      random_r <= jtt_pkg::RANDOM_RST;
    end else if ((wr_en && (reg_i.addr == jtt_pkg::REG_WIRED)) ||
                 ({1'b0, random_r} <= wired_r)) begin
      random_r <= jtt_pkg::RANDOM_RST;
    end else begin
      random_r <= random_r - 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wired_r <= jtt_pkg::WIRED_RST;
    end else if (wr_en && (reg_i.addr == jtt_pkg::REG_WIRED)) begin
      wired_r <= reg_i.wdata[jtt_pkg::WIRED_W-1:0];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo0_r  <= '0;
      lo1_r  <= '0;
      size_r <= '0;
    end else if (cmd_rd) begin
      lo0_r  <= e_lo0[index_r];
      lo1_r  <= e_lo1[index_r];
      size_r <= e_mask[index_r];
    end else if (wr_en) begin
      if (reg_i.addr == jtt_pkg::REG_LO0) begin
        lo0_r <= reg_i.wdata[jtt_pkg::LO_W-1:0];
      end else if (reg_i.addr == jtt_pkg::REG_LO1) begin
        lo1_r <= reg_i.wdata[jtt_pkg::LO_W-1:0];
      end else if (reg_i.addr == jtt_pkg::REG_SIZE) begin
        size_r <= reg_i.wdata[jtt_pkg::SIZE_LSB +: jtt_pkg::MASK_W];
      end
    end
  end
  // hardware updates win over a software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_vpn_r  <= '0;
      hi_address_space_id_r <= '0;
    end else if (lk_miss) begin
      hi_vpn_r <= va[jtt_pkg::VPN_LSB +: jtt_pkg::VPN_W];
    end else if (cmd_rd) begin
      hi_vpn_r  <= e_vpn[index_r];
      hi_address_space_id_r <= e_address_space_id[index_r];
    end else if (wr_en && (reg_i.addr == jtt_pkg::REG_HI)) begin
      hi_vpn_r  <= reg_i.wdata[jtt_pkg::VPN_LSB +: jtt_pkg::VPN_W];
      hi_address_space_id_r <= reg_i.wdata[jtt_pkg::ADDRESS_SPACE_ID_W-1:0];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      badva_r <= '0;
    end else if (lk_miss || lk_aerr) begin
      badva_r <= va;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctx_base_r  <= '0;
      xctx_base_r <= '0;
    end else if (wr_en && (reg_i.addr == jtt_pkg::REG_CTX)) begin
      ctx_base_r <= reg_i.wdata[jtt_pkg::DATA_W-1:jtt_pkg::CTX_LSB];
    end else if (wr_en && (reg_i.addr == jtt_pkg::REG_XCTX)) begin
      xctx_base_r <= reg_i.wdata[jtt_pkg::DATA_W-1:jtt_pkg::XCTX_LSB];
    end
  end
  // interrupt status: set wins over clear
  always_comb begin
    ev = '0;
    ev[jtt_pkg::EV_MISS]  = lk_miss;
    ev[jtt_pkg::EV_AERR]  = lk_aerr;
    ev[jtt_pkg::EV_PFAIL] = cmd_pr && !(|pr_match);
    stat_nxt = stat_r;
    if (wr_en && (reg_i.addr == jtt_pkg::REG_IRQ_CLR)) begin
      stat_nxt = stat_r & ~reg_i.wdata[jtt_pkg::EV_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_r <= '0;
      en_r   <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_en && (reg_i.addr == jtt_pkg::REG_IRQ_EN)) begin
        en_r <= reg_i.wdata[jtt_pkg::EV_W-1:0];
      end
      irq_o <= |(stat_r & en_r);
    end
  end
  // context pointers carry the faulting page number live
  always_comb begin
    if (reg_i.addr == jtt_pkg::REG_INDEX) begin
      rdata_nxt = (64'(pfail_r) << jtt_pkg::PFAIL_BIT) | 64'(index_r);
    end else if (reg_i.addr == jtt_pkg::REG_RANDOM) begin
      rdata_nxt = 64'(random_r);
    end else if (reg_i.addr == jtt_pkg::REG_LO0) begin
      rdata_nxt = 64'(lo0_r);
    end else if (reg_i.addr == jtt_pkg::REG_LO1) begin
      rdata_nxt = 64'(lo1_r);
    end else if (reg_i.addr == jtt_pkg::REG_CTX) begin
      rdata_nxt = {ctx_base_r, badva_r[jtt_pkg::VPN_LSB +: jtt_pkg::BAD32_W],
                   {jtt_pkg::BAD_LSB{1'b0}}};
    end else if (reg_i.addr == jtt_pkg::REG_SIZE) begin
      rdata_nxt = 64'(size_r) << jtt_pkg::SIZE_LSB;
    end else if (reg_i.addr == jtt_pkg::REG_WIRED) begin
      rdata_nxt = 64'(wired_r);
    end else if (reg_i.addr == jtt_pkg::REG_BADVA) begin
      rdata_nxt = badva_r;
    end else if (reg_i.addr == jtt_pkg::REG_HI) begin
      rdata_nxt = (64'(hi_vpn_r) << jtt_pkg::VPN_LSB) | 64'(hi_address_space_id_r);
    end else if (reg_i.addr == jtt_pkg::REG_XCTX) begin
      rdata_nxt = {xctx_base_r, badva_r[jtt_pkg::VPN_LSB +: jtt_pkg::VPN_W],
                   {jtt_pkg::BAD_LSB{1'b0}}};
    end else if (reg_i.addr == jtt_pkg::REG_IRQ_STAT) begin
      rdata_nxt = 64'(stat_r);
    end else if (reg_i.addr == jtt_pkg::REG_IRQ_EN) begin
      rdata_nxt = 64'(en_r);
    end else begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= reg_i.rd ? rdata_nxt : '0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_random_floor: assert property (
    (wired_r < 6'h20) |-> ({1'b0, random_r} >= wired_r) || (random_r == jtt_pkg::RANDOM_RST))
    else $error("random pointer below wired floor");
  a_random_step: assert property (
    !$past(rst_i) && !$past(wr_en && (reg_i.addr == jtt_pkg::REG_WIRED)) &&
    !$past({1'b0, random_r} <= wired_r) |-> random_r == $past(random_r) - 5'h01)
    else $error("random pointer did not step down");
  a_miss_hi_load: assert property (
    lk_miss |=> hi_vpn_r == $past(va[jtt_pkg::VPN_LSB +: jtt_pkg::VPN_W]) && lk_o.miss)
    else $error("miss did not load high half");
  a_miss_badva: assert property (
    lk_o.miss || lk_o.aerr |-> badva_r == $past(va))
    else $error("faulting address not captured");
  a_size_copy: assert property (
    cmd_wr |=> e_mask[$past(wr_idx)] == $past(size_r))
    else $error("size not copied into entry");
  a_index_write: assert property (
    wr_en && (reg_i.addr == jtt_pkg::REG_INDEX) && !cmd_pr |=> index_r == $past(reg_i.wdata[4:0]))
    else $error("index write lost");
  a_reserved_zero: assert property (
    reg_i.rd && (reg_i.addr == 6'h07 || reg_i.addr == 6'h1f) |=> rdata_o == '0)
    else $error("reserved register read nonzero");
  a_user_split: assert property (
    lk_i.valid && !lk_i.mode64 && (lk_i.priv == jtt_pkg::JTT_PRIV_USER) && va[31]
    |=> lk_o.aerr && !lk_o.hit)
    else $error("user access to kernel half not refused");
  a_user_tbyte: assert property (
    lk_i.valid && lk_i.mode64 && (lk_i.priv == jtt_pkg::JTT_PRIV_USER) && (va[63:40] != '0)
    |=> lk_o.aerr)
    else $error("64-bit user access beyond 1 Tbyte accepted");
  a_hit_excl: assert property (
    lk_i.valid |=> $onehot({lk_o.hit, lk_o.miss, lk_o.aerr}))
    else $error("lookup answer not exactly one of hit, miss, error");
  a_irq_level: assert property (
    (stat_r & en_r) != '0 |=> irq_o)
    else $error("interrupt not raised for enabled status");
  c_hit: cover property (lk_i.valid ##1 lk_o.hit);
  c_miss_refill: cover property (lk_o.miss ##[1:20] cmd_wr);
  c_probe_fail: cover property (cmd_pr && !(|pr_match) ##1 stat_r[jtt_pkg::EV_PFAIL]);
endmodule : jtt_top
`default_nettype wire

// ==== jtt_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module jtt_pipe_model (
  input  wire logic                       clk_i,
  input  wire logic [jtt_pkg::DATA_W-1:0] rdata_i,
  input  wire jtt_pkg::jtt_lk_rsp_t       rsp_i,
  output var  jtt_pkg::jtt_reg_req_t      reg_o,
  output var  jtt_pkg::jtt_lk_req_t       lk_o,
  output var  jtt_pkg::jtt_cmd_t          cmd_o
);
  initial begin
    reg_o = '0;
    lk_o  = '0;
    cmd_o = '0;
  end

  // idle fields carry inverted values so a stale request never looks valid
  task automatic reg_op(input logic w, input logic [5:0] a, input logic [63:0] d,
                        output logic [63:0] q);
    @(posedge clk_i);
    reg_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    reg_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata_i;
  endtask : reg_op

  task automatic look(input logic m, input jtt_pkg::jtt_priv_t p, input logic [63:0] va,
                      output jtt_pkg::jtt_lk_rsp_t r);
    @(posedge clk_i);
    lk_o <= '{valid: 1'b1, mode64: m, priv: p, vaddr: va};
    @(posedge clk_i);
    lk_o <= '{valid: 1'b0, mode64: m, priv: p, vaddr: ~va};
    #1 r = rsp_i;
  endtask : look

  task automatic op(input jtt_pkg::jtt_op_t o);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: o};
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
  endtask : op
endmodule : jtt_pipe_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  jtt_pkg::jtt_reg_req_t reg_s;
  jtt_pkg::jtt_lk_req_t  lk_s;
  jtt_pkg::jtt_lk_rsp_t  rsp_s;
  jtt_pkg::jtt_lk_rsp_t  r;
  jtt_pkg::jtt_cmd_t     cmd_s;
  logic [63:0]           rdata_s;
  logic [63:0]           q;
  logic                  irq_s;
  int                    n_errors = 0;
  int                    comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  jtt_top dut (.clk_i(clk_i), .rst_i(rst_i), .reg_i(reg_s), .rdata_o(rdata_s),
               .lk_i(lk_s), .lk_o(rsp_s), .cmd_i(cmd_s), .irq_o(irq_s));
  jtt_pipe_model pipe (.clk_i(clk_i), .rdata_i(rdata_s), .rsp_i(rsp_s),
                       .reg_o(reg_s), .lk_o(lk_s), .cmd_o(cmd_s));

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [63:0] d);
    pipe.reg_op(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string n, input logic [5:0] a, input logic [63:0] e);
    pipe.reg_op(1'b0, a, '0, q);
    chk(n, e, q);
  endtask : rd_chk

  task automatic lk_chk(input logic m, input jtt_pkg::jtt_priv_t p, input logic [63:0] va,
                        input logic [2:0] f, input logic [31:0] pa);
    pipe.look(m, p, va, r);
    chk("lookup", {29'h0, f, pa}, {29'h0, r.hit, r.miss, r.aerr, r.paddr});
  endtask : lk_chk

  task automatic load(input logic [63:0] s, h, l0, l1);
    wr(jtt_pkg::REG_SIZE, s);
    wr(jtt_pkg::REG_HI, h);
    wr(jtt_pkg::REG_LO0, l0);
    wr(jtt_pkg::REG_LO1, l1);
  endtask : load

  task automatic s_regs;
    logic [5:0] rsv [4];
    rsv = '{6'h07, 6'h15, 6'h19, 6'h1f};
    rd_chk("hi reset", jtt_pkg::REG_HI, 64'h0);
    wr(jtt_pkg::REG_INDEX, 64'h1f);
    rd_chk("index", jtt_pkg::REG_INDEX, 64'h1f);
    wr(jtt_pkg::REG_WIRED, 64'h1e);
    wr(jtt_pkg::REG_RANDOM, 64'h0);
    rd_chk("wired", jtt_pkg::REG_WIRED, 64'h1e);
    pipe.reg_op(1'b0, jtt_pkg::REG_RANDOM, '0, q);
    chk("random", 64'h1, {63'h0, q inside {64'h1e, 64'h1f}});
    foreach (rsv[i]) begin
      wr(rsv[i], '1);
      rd_chk("reserved", rsv[i], 64'h0);
    end
    wr(jtt_pkg::REG_WIRED, 64'h0);
  endtask : s_regs

  task automatic s_entry;
    load(64'h7f800, 64'h80005, 64'hfffc002, 64'h4002);
    pipe.op(jtt_pkg::JTT_OP_WIDX);
    load(64'h0, 64'h0, 64'h0, 64'h0);
    pipe.op(jtt_pkg::JTT_OP_READ);
    rd_chk("size", jtt_pkg::REG_SIZE, 64'h7f800);
    rd_chk("lo0", jtt_pkg::REG_LO0, 64'hfffc002);
    rd_chk("lo1", jtt_pkg::REG_LO1, 64'h4002);
    rd_chk("hi", jtt_pkg::REG_HI, 64'h80005);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h81234, 3'b100, 32'hfffc1234);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'hc0abc, 3'b100, 32'h00040abc);
  endtask : s_entry

  task automatic s_miss;
    wr(jtt_pkg::REG_HI, 64'h6);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h81234, 3'b010, 32'h0);
    rd_chk("hi", jtt_pkg::REG_HI, 64'h81006);
    rd_chk("badva", jtt_pkg::REG_BADVA, 64'h81234);
    wr(jtt_pkg::REG_CTX, 64'h2000000);
    wr(jtt_pkg::REG_XCTX, 64'h200000000);
    rd_chk("ctx", jtt_pkg::REG_CTX, 64'h2001020);
    rd_chk("xctx", jtt_pkg::REG_XCTX, 64'h200001020);
    load(64'h0, 64'h2009, 64'h83, 64'hc3);
    wr(jtt_pkg::REG_INDEX, 64'h0);
    pipe.op(jtt_pkg::JTT_OP_WIDX);
    wr(jtt_pkg::REG_HI, 64'h6);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h2010, 3'b100, 32'h810);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h2410, 3'b100, 32'hc10);
  endtask : s_miss

  task automatic s_modes;
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'hffffffff80000000, 3'b001, 32'h0);
    rd_chk("badva", jtt_pkg::REG_BADVA, 64'hffffffff80000000);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_KERN, 64'hffffffff80000040, 3'b100, 32'h40);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_SUPER, 64'hffffffffc0000000, 3'b010, 32'h0);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_SUPER, 64'hffffffffe0000000, 3'b001, 32'h0);
    lk_chk(1'b1, jtt_pkg::JTT_PRIV_USER, 64'h000000fffffff000, 3'b010, 32'h0);
    lk_chk(1'b1, jtt_pkg::JTT_PRIV_USER, 64'h0000010000000000, 3'b001, 32'h0);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h0000000100000000, 3'b001, 32'h0);
  endtask : s_modes

  task automatic s_probe;
    wr(jtt_pkg::REG_HI, 64'h80005);
    pipe.op(jtt_pkg::JTT_OP_PROBE);
    rd_chk("probe", jtt_pkg::REG_INDEX, 64'h1f);
    wr(jtt_pkg::REG_HI, 64'h80007);
    pipe.op(jtt_pkg::JTT_OP_PROBE);
    rd_chk("probe fail", jtt_pkg::REG_INDEX, 64'h8000001f);
  endtask : s_probe

  task automatic s_irq;
    wr(jtt_pkg::REG_IRQ_CLR, 64'h7);
    rd_chk("status", jtt_pkg::REG_IRQ_STAT, 64'h0);
    wr(jtt_pkg::REG_IRQ_EN, 64'h1);
    rd_chk("enable", jtt_pkg::REG_IRQ_EN, 64'h1);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h81234, 3'b010, 32'h0);
    rd_chk("status", jtt_pkg::REG_IRQ_STAT, 64'h1);
    chk("irq", 64'h1, {63'h0, irq_s});
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h80000000, 3'b001, 32'h0);
    wr(jtt_pkg::REG_IRQ_CLR, 64'h1);
    rd_chk("status", jtt_pkg::REG_IRQ_STAT, 64'h2);
    // address error still pending but masked
    chk("irq", 64'h0, {63'h0, irq_s});
    wr(jtt_pkg::REG_IRQ_CLR, 64'h7);
  endtask : s_irq

  // last, since the random slot may overwrite earlier entries
  task automatic s_rnd;
    wr(jtt_pkg::REG_WIRED, 64'h1);
    load(64'h0, 64'h4005, 64'h143, 64'h3);
    pipe.op(jtt_pkg::JTT_OP_WRND);
    lk_chk(1'b0, jtt_pkg::JTT_PRIV_USER, 64'h4020, 3'b100, 32'h1420);
    // the slot under the index pointer must be left alone
    pipe.op(jtt_pkg::JTT_OP_READ);
    rd_chk("rnd spared", jtt_pkg::REG_HI, 64'h80005);
  endtask : s_rnd

  task automatic end_of_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs;
    s_entry;
    s_miss;
    s_modes;
    s_probe;
    s_irq;
    s_rnd;
    end_of_test;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
